// ---- inc/mmsd_pkg.sv ----
package mmsd_pkg;
   localparam int PA_W = 12;
   localparam int DA_W = 8;
   localparam int STACK_DEPTH = 6;
   localparam int BLK_W = 6;
   localparam logic [7:0] WIN_LO = 8'h40;
   localparam logic [7:0] WIN_HI = 8'h7F;
   localparam logic [7:0] RAM_LO = 8'h00;
   localparam logic [7:0] RAM_HI = 8'h3F;
   localparam logic [7:0] REG_LO = 8'h80;
   localparam logic [7:0] SEL_ADDR = 8'hC9;
   localparam logic [11:0] PC_RST = 12'hFFE;
   localparam logic [5:0] SEL_RST = 6'h00;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mmsd_dreq_s;

   typedef enum logic [2:0] {
      MMSD_RAM = 3'b001,
      MMSD_WIN = 3'b010,
      MMSD_REG = 3'b100
   } mmsd_region_e;
endpackage : mmsd_pkg

// ---- hw/mmsd_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Program, data and stack spaces are separate storage; data space sees program memory only through the window.
// - Stack holds six return address levels for calls and interrupts.
// - Program fetch address is a 12-bit instruction pointer, 4K reach.
// - Program memory holds code, immediates, test area and vectors.
// - With protection set, external program memory reads are refused.
// - Protection clears only with full erase, which wipes program memory.
// - Data space decodes RAM, core/peripheral registers and constant window.
// - Constants in program memory are reached only through a 64-byte window.
// - Core registers, ports, interrupt option and window select live in data space.
// - Window spans 40h-7Fh, block chosen by the select register.
// - Select register is write-only, undefined at reset; write before use (srst_i loads SEL_RST, 0, here).
// - Each stack level is 12 bits wide.
module mmsd_top import mmsd_pkg::*; #(
   parameter int PMEM_BYTES = 4096
) (
   input  wire logic            sys_clk_i,
   input  wire logic            srst_i,
   input  wire logic [PA_W-1:0] instruction_pointer_i,
   input  wire mmsd_dreq_s      dreq_i,
   input  wire logic            push_i,
   input  wire logic            pop_i,
   input  wire logic [PA_W-1:0] push_addr_i,
   input  wire logic            ext_rd_i,
   input  wire logic [PA_W-1:0] ext_addr_i,
   input  wire logic            prot_set_i,
   input  wire logic            erase_i,
   input  wire logic            prog_wr_i,
   input  wire logic [PA_W-1:0] prog_addr_i,
   input  wire logic [7:0]      prog_data_i,
   input  wire logic [7:0]      reg_rdata_i,
   output logic [7:0]           fetch_data_o,
   output logic [7:0]           drdata_o,
   output logic                 reg_sel_o,
   output logic [PA_W-1:0]      pop_addr_o,
   output logic [7:0]           ext_data_o,
   output logic                 ext_refused_o,
   output logic                 prot_o
);
   logic [7:0]      pmem  [PMEM_BYTES];
   logic [7:0]      ram   [64];
   logic [PA_W-1:0] stack [STACK_DEPTH];
   logic [BLK_W-1:0] rom_window_block_select;
   logic [2:0]      depth;
   logic            prot;
   logic [PA_W-1:0] erase_ptr;
   logic            erasing;
   mmsd_region_e    region;

   function automatic mmsd_region_e decode(input logic [7:0] a);
      if (a >= WIN_LO && a <= WIN_HI) return MMSD_WIN;
      if (a <= RAM_HI) return MMSD_RAM;
      return MMSD_REG;
   endfunction : decode

   always_comb begin
      region = decode(dreq_i.addr);
   end

   // Program memory: loader writes, or a full erase sweep
   always_ff @(posedge sys_clk_i) begin
      if (erasing) begin
         pmem[erase_ptr] <= 8'hFF;
      end else if (prog_wr_i && !prot) begin
         pmem[prog_addr_i] <= prog_data_i;
      end
   end

   a_erase_wipe: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      erasing |=> pmem[$past(erase_ptr)] == 8'hFF) else $error("erase left a byte unwiped");
   a_prog_locked: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      prog_wr_i && prot && !erasing |=> pmem[$past(prog_addr_i)] == $past(pmem[prog_addr_i]))
      else $error("protected program write landed");

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         erasing   <= 1'b0;
         erase_ptr <= '0;
      end else if (erasing) begin
         erase_ptr <= erase_ptr + 12'h001;
         if (erase_ptr == 12'(PMEM_BYTES - 1)) erasing <= 1'b0;
      end else if (erase_i) begin
         erasing   <= 1'b1;
         erase_ptr <= '0;
      end
   end

   // Protection is nonvolatile in silicon, so reset does not clear it
   always_ff @(posedge sys_clk_i) begin
      // Set beats a same-cycle erase end, so a fresh lock is never lost
      if (prot_set_i) prot <= 1'b1;
      else if (erasing && erase_ptr == 12'(PMEM_BYTES - 1)) prot <= 1'b0;
      else if (srst_i && prot !== 1'b1) prot <= 1'b0;
   end

   a_prot_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $fell(prot) |-> $past(erasing) && $past(erase_ptr) == 12'(PMEM_BYTES - 1))
      else $error("protection dropped without erase");
   a_erase_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      erasing && erase_ptr == 12'(PMEM_BYTES - 1) && !prot_set_i |=> !prot && !erasing)
      else $error("erase end did not unlock");

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         fetch_data_o <= '0;
      end else begin
         fetch_data_o <= pmem[instruction_pointer_i[PA_W-1:0]];
      end
   end

   // Select register has no reset in silicon; zero here only for clean sim
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rom_window_block_select <= SEL_RST;
      end else if (dreq_i.wr && dreq_i.addr == SEL_ADDR) begin
         rom_window_block_select <= dreq_i.wdata[BLK_W-1:0];
      end
   end

   a_sel_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dreq_i.wr && dreq_i.addr == SEL_ADDR |=> rom_window_block_select == $past(dreq_i.wdata[5:0]))
      else $error("select write lost");

   always_ff @(posedge sys_clk_i) begin
      if (dreq_i.wr && region == MMSD_RAM) ram[dreq_i.addr[5:0]] <= dreq_i.wdata;
   end

   // One-cycle read: window fetch uses block*64+k directly
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         drdata_o <= '0;
      end else if (dreq_i.rd) begin
         case (region)
            MMSD_WIN: drdata_o <= pmem[{rom_window_block_select, dreq_i.addr[5:0]}];
            MMSD_RAM: drdata_o <= ram[dreq_i.addr[5:0]];
            MMSD_REG: drdata_o <= (dreq_i.addr == SEL_ADDR) ? 8'h00 : reg_rdata_i;
            default:  drdata_o <= '0;
         endcase
      end
   end

   a_win_sel: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dreq_i.rd && region == MMSD_WIN && !erasing && !prog_wr_i
      |=> drdata_o == pmem[{$past(rom_window_block_select), $past(dreq_i.addr[5:0])}])
      else $error("window read wrong byte");
   a_ram_data: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dreq_i.rd && !dreq_i.wr && region == MMSD_RAM |=> drdata_o == ram[$past(dreq_i.addr[5:0])])
      else $error("ram read wrong byte");
   a_reg_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dreq_i.rd && region == MMSD_REG && dreq_i.addr != SEL_ADDR |=> drdata_o == $past(reg_rdata_i))
      else $error("register read not forwarded");
   a_sel_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dreq_i.rd && dreq_i.addr == SEL_ADDR |=> drdata_o == 8'h00) else $error("select read not zero");
   a_drdata_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !dreq_i.rd |=> $stable(drdata_o)) else $error("read data did not stand");

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) reg_sel_o <= 1'b0;
      else reg_sel_o <= (dreq_i.rd || dreq_i.wr) && region == MMSD_REG;
   end

   a_win_decode: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (dreq_i.addr >= 8'h40 && dreq_i.addr <= 8'h7F) == (region == MMSD_WIN))
      else $error("window decode wrong");
   a_reg_sel: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dreq_i.rd && region == MMSD_WIN |=> !reg_sel_o) else $error("window aliased to regs");

   // Stack: full push shifts out the oldest level
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         depth <= '0;
      end else if (push_i) begin
         for (int i = STACK_DEPTH - 1; i > 0; i--) stack[i] <= stack[i-1];
         stack[0] <= push_addr_i;
         if (depth != 3'(STACK_DEPTH)) depth <= depth + 3'd1;
      end else if (pop_i && depth != 3'd0) begin
         for (int i = 0; i < STACK_DEPTH - 1; i++) stack[i] <= stack[i+1];
         depth <= depth - 3'd1;
      end
   end

   a_stack_depth: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      depth <= 3'(STACK_DEPTH)) else $error("stack depth overflow");
   a_push_full: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      push_i && depth == 3'(STACK_DEPTH) |=> depth == 3'(STACK_DEPTH) && stack[0] == $past(push_addr_i))
      else $error("full push mishandled");
   a_push_count: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      push_i && depth != 3'(STACK_DEPTH) |=> depth == $past(depth) + 3'd1)
      else $error("push did not deepen stack");
   a_pop_count: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pop_i && !push_i && depth != 3'd0 |=> depth == $past(depth) - 3'd1)
      else $error("pop did not shrink stack");

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) pop_addr_o <= '0;
      else if (pop_i && !push_i && depth != 3'd0) pop_addr_o <= stack[0];
   end

   a_pop_data: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pop_i && !push_i && depth != 3'd0 |=> pop_addr_o == $past(stack[0])) else $error("pop data wrong");
   a_pop_empty: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pop_i && !push_i && depth == 3'd0 |=> $stable(pop_addr_o)) else $error("empty pop moved output");

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ext_data_o    <= '0;
         ext_refused_o <= 1'b0;
         prot_o        <= 1'b0;
      end else begin
         prot_o        <= prot;
         ext_refused_o <= ext_rd_i && prot;
         ext_data_o    <= (ext_rd_i && !prot) ? pmem[ext_addr_i] : 8'h00;
      end
   end

   a_ext_refuse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ext_rd_i && prot |=> ext_refused_o && ext_data_o == 8'h00)
      else $error("protected read not refused");
   a_ext_data: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ext_rd_i && !prot && !prog_wr_i && !erasing |=> !ext_refused_o && ext_data_o == pmem[$past(ext_addr_i)])
      else $error("open read wrong");
endmodule : mmsd_top

// ---- testbench/mmsd_core_model.sv ----
`timescale 1ns/1ps
module mmsd_core_model import mmsd_pkg::*; (
   input  wire logic sys_clk_i,
   output mmsd_dreq_s dreq_o
);
   initial dreq_o = '0;
   // One data access, driven off the clock edge; released lines show the inverse
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      dreq_o = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge sys_clk_i);
      dreq_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask : acc
endmodule : mmsd_core_model

// ---- testbench/test_mmsd_top.sv ----
`timescale 1ns/1ps
module test_mmsd_top import mmsd_pkg::*; ;
   logic        sys_clk_i = 0, srst_i = 1, push_i = 0, pop_i = 0, ext_rd_i = 0;
   logic        prot_set_i = 0, erase_i = 0, prog_wr_i = 0, reg_sel, ext_ref, prot;
   logic [11:0] ip = 0, push_a = 0, ext_a = 0, prog_a = 0, pop_a;
   logic [7:0]  prog_d = 0, fetch_d, dr_d, ext_d;
   mmsd_dreq_s  dreq;
   int          n_errors = 0, cmp_count = 0;
   // Program address beside the byte stored there
   logic [19:0] rows [5] = '{20'h0_003C, 20'h0_85A7, 20'h3_FF19, 20'hF_C0E2, 20'hF_FF6D};
   mmsd_core_model i_mmsd_core_model (.sys_clk_i(sys_clk_i), .dreq_o(dreq));
   mmsd_top i_mmsd_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .instruction_pointer_i(ip),
      .dreq_i(dreq), .push_i(push_i), .pop_i(pop_i), .push_addr_i(push_a), .ext_rd_i(ext_rd_i),
      .ext_addr_i(ext_a), .prot_set_i(prot_set_i), .erase_i(erase_i), .prog_wr_i(prog_wr_i),
      .prog_addr_i(prog_a), .prog_data_i(prog_d), .reg_rdata_i(8'hA5), .fetch_data_o(fetch_d),
      .drdata_o(dr_d), .reg_sel_o(reg_sel), .pop_addr_o(pop_a), .ext_data_o(ext_d),
      .ext_refused_o(ext_ref), .prot_o(prot));
   initial forever #5 sys_clk_i = ~sys_clk_i;
   task automatic report_and_stop;
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic pulse(ref logic s);
      @(negedge sys_clk_i) s = 1;
      @(negedge sys_clk_i) s = 0;
   endtask : pulse
   // Fetch needs the pointer held while the registered byte settles
   task automatic fetch(input logic [11:0] a);
      ip = a;
      repeat (2) @(negedge sys_clk_i);
   endtask : fetch
   initial begin
      repeat (20) @(negedge sys_clk_i);
      srst_i = 0;
      chk("drdata", 0, dr_d); // RESET
      chk("pop_addr", 0, pop_a); // RESET
      foreach (rows[i]) begin
         prog_a = rows[i][19:8];
         prog_d = rows[i][7:0];
         pulse(prog_wr_i);
      end
      foreach (rows[i]) begin
         i_mmsd_core_model.acc(1, SEL_ADDR, {2'b00, rows[i][19:14]});
         i_mmsd_core_model.acc(0, WIN_LO | {2'b00, rows[i][13:8]}, 0);
         chk("window", rows[i][7:0], dr_d);
         fetch(rows[i][19:8]);
         chk("fetch", rows[i][7:0], fetch_d);
         ext_a = rows[i][19:8];
         pulse(ext_rd_i);
         chk("ext_data", rows[i][7:0], ext_d);
      end
      i_mmsd_core_model.acc(1, 8'h00, 8'hC3);
      i_mmsd_core_model.acc(0, WIN_LO, 0);
      chk("window", 12'h0E2, dr_d);
      i_mmsd_core_model.acc(0, 8'h00, 0);
      chk("ram", 12'h0C3, dr_d);
      chk("reg_sel", 0, reg_sel);
      i_mmsd_core_model.acc(0, SEL_ADDR, 0);
      chk("select", 0, dr_d);
      i_mmsd_core_model.acc(0, 8'hFF, 0);
      chk("reg_sel", 1, reg_sel);
      chk("reg_data", 12'h0A5, dr_d);
      // Seven pushes on a six deep stack lose the first one
      for (int i = 1; i <= 7; i++) begin
         push_a = 12'(i * 12'h201);
         pulse(push_i);
      end
      for (int i = 7; i >= 2; i--) begin
         pulse(pop_i);
         chk("pop_addr", 12'(i * 12'h201), pop_a);
      end
      pulse(pop_i);
      chk("pop_addr", 12'h402, pop_a);
      pulse(prot_set_i);
      // Status output trails the lock flag by one register stage
      @(negedge sys_clk_i);
      chk("prot", 1, prot);
      srst_i = 1;
      repeat (2) @(negedge sys_clk_i);
      srst_i = 0;
      chk("drdata", 0, dr_d); // RESET
      chk("pop_addr", 0, pop_a); // RESET
      @(negedge sys_clk_i);
      chk("prot", 1, prot);
      ext_a = 12'h085;
      pulse(ext_rd_i);
      chk("refused", 1, ext_ref);
      chk("ext_data", 0, ext_d);
      prog_a = 12'h085;
      prog_d = 8'h11;
      pulse(prog_wr_i);
      fetch(12'h085);
      chk("fetch", 12'h0A7, fetch_d);
      pulse(erase_i);
      repeat (4096 + 8) @(negedge sys_clk_i);
      chk("prot", 0, prot);
      fetch(12'hFFF);
      chk("fetch", 12'h0FF, fetch_d);
      fetch(12'h085);
      chk("fetch", 12'h0FF, fetch_d);
      report_and_stop;
   end
   // Whole run is near 4230 cycles; cut a hang well beyond that
   initial begin
      #600_000;
      n_errors++;
      report_and_stop;
   end
endmodule : test_mmsd_top
